// *** strap_cfg_pkg.sv ***
// Overview of operation
// - The strap-selected functions are taken from the strap pins at reset, before firmware runs.
// - Each strap reads as zero and selects the default function unless the board pulls it high.
// - The two width straps give the boot ROM width: 00 is x8, 01 reserved, 10 x16, 11 x32.
// - The wide-ROM buffer enable is active only for x32 and then asserts on every ROM select access.
// - Buffer-select strap 1 puts transceiver controls on three pins, 0 puts the three GP selects.
// - Once strapped, the transceiver controls are driven from boot on for every peripheral bus access.
// - Transceiver control enabling depends only on the buffer-select strap, not on firmware bus mode.
// - The strapped boot ROM width is only an initial value that firmware may change.
// - Steering strap 0 sends the boot ROM decode to the ROM pin, 1 sends it to socket A selects.
// - The width straps set the decode width whichever way the decode is steered.
// - Firmware may enable or disable the socket remapping at any time once the straps have been captured.
// - While redirected, all normal socket controller features still drive socket A.
// - Scan-enable strap 1 gives the four test pins their scan roles, 0 gives them to the socket.
package strap_cfg_pkg;

	typedef enum logic [1:0] {
		ROM_W8,
		ROM_W16,
		ROM_W32
	} rom_width_t;

	localparam logic [1:0] WIDTH_CODE_X8 = 2'h0;
	localparam logic [1:0] WIDTH_CODE_RSVD = 2'h1;
	localparam logic [1:0] WIDTH_CODE_X16 = 2'h2;
	localparam logic [1:0] WIDTH_CODE_X32 = 2'h3;

	// Captured strap levels.
	typedef struct packed {
		logic width_hi;
		logic width_lo;
		logic steer;
		logic buf_sel;
		logic scan_en;
	} straps_t;

	localparam straps_t STRAPS_RESET = '0;

	// Enabled edges after reset release before the synchronised straps are valid.
	localparam logic [1:0] CAPTURE_DELAY = 2'h2;

	// Firmware-side configuration.
	typedef struct packed {
		logic width_wr;
		rom_width_t width_val;
		logic remap_wr;
		logic remap_val;
	} fw_cfg_t;

	// Scan pin roles.
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic tdo;
	} scan_pins_t;

endpackage

// *** reset_strap_pin_config.sv ***
`timescale 1ns/100ps
`default_nettype none
module reset_strap_pin_config
	import strap_cfg_pkg::*;
(
	// Clock, reset, enable.
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// Strap pins, asynchronous.
	input wire logic rom_width_strap_lo_i,
	input wire logic rom_width_strap_hi_i,
	input wire logic boot_decode_steer_strap_i,
	input wire logic bus_buffer_select_strap_i,
	input wire logic scan_port_enable_strap_i,
	// Firmware configuration.
	input wire fw_cfg_t fw_cfg_i,
	// Internal bus activity.
	input wire logic boot_rom_decode_i,
	input wire logic rom_selects_any_i,
	input wire logic periph_access_i,
	input wire logic periph_read_low_i,
	input wire logic periph_read_high_i,
	input wire logic [2:0] gp_chip_select_i,
	input wire logic [3:0] socket_cs_i,
	input wire scan_pins_t socket_pin_i,
	input wire scan_pins_t scan_core_i,
	// Pin outputs.
	output logic boot_rom_select_o,
	output logic [1:0] socket_a_cs_o,
	output logic wide_rom_buffer_oe_o,
	output logic [2:0] shared_pin_o,
	output scan_pins_t test_pin_o,
	output logic scan_mode_o,
	output rom_width_t rom_width_o,
	output logic remap_active_o,
	output logic xcvr_mode_o
);

	// ==============================================================
	// State.
	typedef struct packed {
		straps_t meta;
		straps_t sync;
		straps_t held;
		logic captured;
		logic [1:0] settle;
		rom_width_t width;
		logic remap;
		logic boot_cs;
		logic [1:0] sock_cs;
		logic wide_oe;
		logic [2:0] shared;
		scan_pins_t test;
	} state_t;

	state_t s_q;
	state_t s_d;

	function automatic rom_width_t decode_width(input logic [1:0] code);
		case (code)
			WIDTH_CODE_X8: decode_width = ROM_W8;
			WIDTH_CODE_RSVD: decode_width = ROM_W8;
			WIDTH_CODE_X16: decode_width = ROM_W16;
			WIDTH_CODE_X32: decode_width = ROM_W32;
			default: decode_width = ROM_W8;
		endcase
	endfunction

	straps_t pins;
	logic [1:0] wcode;
	logic xcvr;

	// ==============================================================
	// Next state.
	always_comb begin
		pins = '{width_hi: rom_width_strap_hi_i, width_lo: rom_width_strap_lo_i,
			steer: boot_decode_steer_strap_i, buf_sel: bus_buffer_select_strap_i,
			scan_en: scan_port_enable_strap_i};
		s_d = s_q;
		s_d.meta = pins;
		s_d.sync = s_q.meta;
		wcode = {s_q.sync.width_hi, s_q.sync.width_lo};
		// Capture once the synchroniser has filled, then freeze until next reset.
		if (!s_q.captured) begin
			if (s_q.settle == CAPTURE_DELAY) begin
				s_d.held = s_q.sync;
				s_d.captured = 1'b1;
				s_d.width = decode_width(wcode);
				s_d.remap = s_q.sync.steer;
			end else begin
				s_d.settle = s_q.settle + 2'h1;
			end
		end else begin
			if (fw_cfg_i.width_wr) begin
				s_d.width = fw_cfg_i.width_val;
			end
			if (fw_cfg_i.remap_wr) begin
				s_d.remap = fw_cfg_i.remap_val;
			end
		end
		xcvr = s_q.held.buf_sel;
		// Boot decode goes to pin or socket; socket keeps its own selects.
		s_d.boot_cs = s_q.captured && boot_rom_decode_i && !s_q.remap;
		s_d.sock_cs = socket_cs_i[1:0] | {2{s_q.captured && boot_rom_decode_i && s_q.remap}};
		s_d.wide_oe = s_q.captured && s_q.width == ROM_W32 && rom_selects_any_i;
		if (xcvr) begin
			s_d.shared = {periph_read_high_i, periph_read_low_i, periph_access_i};
		end else begin
			s_d.shared = gp_chip_select_i;
		end
		if (s_q.held.scan_en) begin
			s_d.test = scan_core_i;
		end else begin
			s_d.test = socket_pin_i;
		end
	end

	// ==============================================================
	// Registers.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			s_q <= '{meta: STRAPS_RESET, sync: STRAPS_RESET, held: STRAPS_RESET,
				captured: 1'b0, settle: 2'h0, width: ROM_W8, remap: 1'b0, boot_cs: 1'b0,
				sock_cs: 2'h0, wide_oe: 1'b0, shared: 3'h0, test: '0};
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign boot_rom_select_o = s_q.boot_cs;
	assign socket_a_cs_o = s_q.sock_cs;
	assign wide_rom_buffer_oe_o = s_q.wide_oe;
	assign shared_pin_o = s_q.shared;
	assign test_pin_o = s_q.test;
	assign scan_mode_o = s_q.held.scan_en;
	assign rom_width_o = s_q.width;
	assign remap_active_o = s_q.remap;
	assign xcvr_mode_o = s_q.held.buf_sel;

endmodule
`default_nettype wire

// *** strap_board.sv ***
`timescale 1ns/100ps
`default_nettype none
module strap_board (
	// Resistors fitted on the board, one per strap.
	input wire logic [4:0] fit_i,
	// An unfitted strap sits at the weak pull-down level.
	output logic [4:0] strap_o
);
	assign strap_o = fit_i;
endmodule
`default_nettype wire

// *** strap_pins_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module strap_pins_checker
	import strap_cfg_pkg::*;
(
	input wire logic mclk_i, srst_i, ce_i, boot_rom_decode_i, rom_selects_any_i, periph_access_i,
	input wire logic periph_read_low_i, periph_read_high_i, boot_rom_select_o,
	input wire logic wide_rom_buffer_oe_o, scan_mode_o, remap_active_o, xcvr_mode_o,
	input wire logic [1:0] socket_a_cs_o,
	input wire logic [2:0] gp_chip_select_i, shared_pin_o,
	input wire rom_width_t rom_width_o,
	input wire scan_pins_t scan_core_i, test_pin_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	// Counts enabled edges after reset; 3 means the straps have been captured.
	logic [1:0] up_q;
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			up_q <= 2'h0;
		end else if (ce_i && up_q != 2'h3) begin
			up_q <= up_q + 2'h1;
		end
	end
	a_rom_path: assert property (
		$past(up_q == 2'h3 && ce_i && !remap_active_o) |->
			boot_rom_select_o == $past(boot_rom_decode_i)
	) else $error("boot select wrong");
	a_socket_path: assert property (
		$past(up_q == 2'h3 && ce_i && remap_active_o && boot_rom_decode_i) |->
			socket_a_cs_o == 2'h3 && !boot_rom_select_o
	) else $error("socket select wrong");
	a_wide_oe_x32: assert property (
		$past(up_q == 2'h3 && ce_i) |->
			wide_rom_buffer_oe_o == $past(rom_selects_any_i && rom_width_o == ROM_W32)
	) else $error("wide buffer enable wrong");
	a_xcvr_pins: assert property (
		$past(ce_i && xcvr_mode_o) |->
			shared_pin_o == $past({periph_read_high_i, periph_read_low_i, periph_access_i})
	) else $error("transceiver pins wrong");
	a_gp_pins: assert property (
		$past(ce_i && !xcvr_mode_o && !srst_i) |-> shared_pin_o == $past(gp_chip_select_i)
	) else $error("chip select pins wrong");
	a_scan_pins: assert property ($past(ce_i && scan_mode_o) |-> test_pin_o == $past(scan_core_i))
		else $error("scan pins wrong");
	a_xcvr_hold: assert property ($past(xcvr_mode_o) |-> xcvr_mode_o)
		else $error("transceiver mode lost");
	a_scan_hold: assert property ($past(scan_mode_o) |-> scan_mode_o)
		else $error("scan mode lost");
endmodule
bind reset_strap_pin_config strap_pins_checker chk (.*);
`default_nettype wire

// *** reset_strap_pin_config_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module reset_strap_pin_config_bench;
	import strap_cfg_pkg::*;
	`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
		$display("[ERR] %0t %h %h", $time, a, e); end end
	logic mclk_i = 0, srst_i = 1, ce_i = 1, boot_rom_decode_i = 0, rom_selects_any_i = 0;
	logic periph_access_i = 0, periph_read_low_i = 0, periph_read_high_i = 0, r;
	logic boot_rom_select_o, wide_rom_buffer_oe_o, scan_mode_o, remap_active_o, xcvr_mode_o;
	logic [1:0] socket_a_cs_o, hs;
	logic [2:0] gp_chip_select_i = 0, shared_pin_o, xp;
	logic [3:0] socket_cs_i = 0;
	logic [4:0] fit = 0, s;
	wire rom_width_strap_lo_i, rom_width_strap_hi_i, boot_decode_steer_strap_i;
	wire bus_buffer_select_strap_i, scan_port_enable_strap_i;
	fw_cfg_t fw_cfg_i = '0;
	scan_pins_t socket_pin_i = '0, scan_core_i = '0, test_pin_o;
	rom_width_t rom_width_o, w;
	int n_mismatch = 0, num_checks = 0;
	reset_strap_pin_config uut (.*);
	strap_board brd (.fit_i(fit), .strap_o({rom_width_strap_hi_i, rom_width_strap_lo_i,
		boot_decode_steer_strap_i, bus_buffer_select_strap_i, scan_port_enable_strap_i}));
	always #2 mclk_i = ~mclk_i;
	task stop_test;
		if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		#8000;
		n_mismatch++;
		stop_test;
	end
	initial begin
		void'($urandom(32'h3597));
		for (int i = 0; i < 32; i++) begin
			if (i[4:3] == 2'h3 && i[2]) continue;
			fit = i[4:0];
			srst_i = 1;
			repeat (4) @(posedge mclk_i);
			#1 srst_i = 0;
			repeat (5) @(posedge mclk_i);
			#1 s = fit;
			fit = ~fit;
			w = s[4:3] == 2'h3 ? ROM_W32 : (s[4] ? ROM_W16 : ROM_W8);
			r = s[2];
			for (int k = 0; k < 20; k++) begin
				{boot_rom_decode_i, rom_selects_any_i, periph_access_i, periph_read_low_i,
					periph_read_high_i, gp_chip_select_i, socket_cs_i, socket_pin_i,
					scan_core_i} = 20'($urandom);
				fw_cfg_i = '0;
				if (k == 10) fw_cfg_i = '{1'b1, rom_width_t'(2'($urandom % 3)), 1'b1, 1'($urandom)};
				hs = socket_a_cs_o;
				ce_i = (k != 15);
				@(posedge mclk_i);
				#1;
				if (k == 10) begin
					w = fw_cfg_i.width_val;
					r = fw_cfg_i.remap_val;
				end else if (k == 15) begin
					`CHK(socket_a_cs_o, hs)
				end else begin
					xp = s[1] ? {periph_read_high_i, periph_read_low_i, periph_access_i} : gp_chip_select_i;
					`CHK(rom_width_o, w)
					`CHK(xcvr_mode_o, s[1])
					`CHK(scan_mode_o, s[0])
					`CHK(remap_active_o, r)
					`CHK(boot_rom_select_o, boot_rom_decode_i & ~r)
					`CHK(socket_a_cs_o, socket_cs_i[1:0] | {2{boot_rom_decode_i & r}})
					`CHK(wide_rom_buffer_oe_o, rom_selects_any_i & (w == ROM_W32))
					`CHK(shared_pin_o, xp)
					`CHK(test_pin_o, s[0] ? scan_core_i : socket_pin_i)
				end
			end
		end
		stop_test;
	end
endmodule
`default_nettype wire
